//--- hdl/tcwa_pkg.sv
package tcwa_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets on the bus
	localparam logic [7:0] OFS_TXDATA = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_INTCLR = 8'h08;
	localparam logic [7:0] OFS_INTEN = 8'h0c;
	localparam logic [7:0] OFS_CMDINFO = 8'h10;
	localparam logic [7:0] OFS_PADCNT = 8'h14;

	////////////////////////////////////////////////////////////////////////////////
	// first command word fields
	localparam int IOC_BIT = 31;
	localparam int ALIGN_HI = 25;
	localparam int ALIGN_LO = 24;
	localparam int START_HI = 20;
	localparam int START_LO = 16;
	localparam int SIZE_HI = 10;
	localparam int SIZE_LO = 0;

	localparam logic [1:0] ALIGN_4 = 2'h0;
	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	localparam logic [1:0] ALIGN_RSV = 2'h3;

	// word rounding masks for 16 and 32 byte ends
	localparam logic [9:0] ROUND_16 = 10'h003;
	localparam logic [9:0] ROUND_32 = 10'h007;

	////////////////////////////////////////////////////////////////////////////////
	// status / interrupt bits and reset values
	localparam int STS_LOADED = 0;
	localparam int STS_ERROR = 1;
	localparam int STATE_LO = 4;
	localparam logic [1:0] STS_RESET = 2'h0;
	localparam logic [1:0] EN_RESET = 2'h0;

	localparam logic [1:0] HTRANS_IDLE = 2'h0;

	typedef logic [9:0] tcwa_wcnt_t;

	typedef enum logic [1:0] {
		ST_CMDA = 2'b00,
		ST_CMDB = 2'b01,
		ST_DATA = 2'b10,
		ST_PAD = 2'b11
	} tcwa_state_e;

endpackage

//--- hdl/tcwa_cmd_decode.sv
`timescale 1ns/10ps
module tcwa_cmd_decode (
	input wire logic [31:0] cmd_word, // first command word
	output logic ioc, // completion flag requested
	output logic align_bad, // reserved alignment code
	output logic [2:0] skip_words, // whole words ahead of data
	output logic [1:0] first_lane, // first valid byte lane
	output logic [1:0] end_lane, // lane just past last byte
	output tcwa_pkg::tcwa_wcnt_t data_words, // words up to last data byte
	output tcwa_pkg::tcwa_wcnt_t total_words // words including end padding
);
	import tcwa_pkg::*;

	logic [11:0] end_byte;
	logic [11:0] end_round;
	tcwa_wcnt_t round_mask;

	always_comb begin
		ioc = cmd_word[IOC_BIT];
		// bits 30:26 and 23:21 are never looked at
		skip_words = cmd_word[START_HI:START_LO+2];
		first_lane = cmd_word[START_LO+1:START_LO];
		// start offset plus byte count gives the end of valid data
		end_byte = {7'h00, cmd_word[START_HI:START_LO]} + {1'b0, cmd_word[SIZE_HI:SIZE_LO]};
		end_lane = end_byte[1:0];
		end_round = end_byte + 12'h003;
		data_words = end_round[11:2];
		align_bad = 1'b0;
		case (cmd_word[ALIGN_HI:ALIGN_LO])
			ALIGN_4: round_mask = 10'h000;
			ALIGN_16: round_mask = ROUND_16;
			ALIGN_32: round_mask = ROUND_32;
			default: begin
				// reserved code runs as plain word alignment
				round_mask = 10'h000;
				align_bad = 1'b1;
			end
		endcase
		total_words = (data_words + round_mask) & ~round_mask;
	end

endmodule

//--- hdl/tcwa_tx_cmd_a.sv
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
// Behaviour
// - completion bit sets loaded flag after buffer
// - loaded flag may drive host interrupt
// - alignment code 00/01/10 gives 4/16/32 bytes
// - padding words are dropped, never forwarded
// - five-bit start offset, earlier bytes ignored
// - low eleven bits are buffer byte count
// - upper offset bits skip whole words
module tcwa_tx_cmd_a (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write access
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready in
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	output logic tx_valid, // word to fifo controller
	input wire logic tx_ready, // fifo controller takes word
	output logic [31:0] tx_data, // forwarded data word
	output logic [3:0] tx_ben, // valid byte lanes
	output logic tx_last, // last data word of buffer
	output logic irq // host interrupt
);
	import tcwa_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic hreadyout_r, hreadyout_nxt;
	logic wpend_r, wpend_nxt;
	logic rpend_r, rpend_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	tcwa_state_e st_r, st_nxt;
	tcwa_wcnt_t wcnt_r, wcnt_nxt;
	logic ioc_r, ioc_nxt;
	logic [1:0] align_r, align_nxt;
	logic [2:0] skip_r, skip_nxt;
	logic [1:0] flane_r, flane_nxt;
	logic [1:0] elane_r, elane_nxt;
	tcwa_wcnt_t dwords_r, dwords_nxt;
	tcwa_wcnt_t twords_r, twords_nxt;
	logic [15:0] padcnt_r, padcnt_nxt;
	logic [1:0] sts_r, sts_nxt;
	logic [1:0] en_r, en_nxt;
	logic irq_r, irq_nxt;
	logic tx_valid_r, tx_valid_nxt;
	logic [31:0] tx_data_r, tx_data_nxt;
	logic [3:0] tx_ben_r, tx_ben_nxt;
	logic tx_last_r, tx_last_nxt;

	logic dec_ioc, dec_bad;
	logic [2:0] dec_skip;
	logic [1:0] dec_flane, dec_elane;
	tcwa_wcnt_t dec_dwords, dec_twords;

	logic addr_take, dp_wr, in_data, slot_free, fwd, bus_done, word_take, load_slot, buf_done;
	logic clr_hit;
	logic [3:0] cur_ben;
	logic [1:0] sts_set;
	tcwa_wcnt_t wcnt_inc;

	tcwa_cmd_decode u_dec (
		.cmd_word(hwdata),
		.ioc(dec_ioc),
		.align_bad(dec_bad),
		.skip_words(dec_skip),
		.first_lane(dec_flane),
		.end_lane(dec_elane),
		.data_words(dec_dwords),
		.total_words(dec_twords)
	);

	////////////////////////////////////////////////////////////////////////////////
	// word handling decisions
	always_comb begin
		addr_take = hsel && hready && (htrans != HTRANS_IDLE) && htrans[1];
		dp_wr = wpend_r && (addr_r == OFS_TXDATA);
		in_data = (st_r == ST_DATA) || (st_r == ST_PAD);
		wcnt_inc = wcnt_r + 10'h001;
		cur_ben = 4'hf;
		if ((wcnt_r < {7'h00, skip_r}) || (wcnt_r >= dwords_r)) begin
			cur_ben = 4'h0;
		end else begin
			if (wcnt_r == {7'h00, skip_r}) begin
				cur_ben = cur_ben & (4'hf << flane_r);
			end
			if ((wcnt_r == dwords_r - 10'h001) && (elane_r != 2'h0)) begin
				cur_ben = cur_ben & (4'hf >> (3'd4 - {1'b0, elane_r}));
			end
		end
		// a word with no valid lane (empty buffer, odd offset) is dropped too
		fwd = dp_wr && in_data && (cur_ben != 4'h0);
		slot_free = !tx_valid_r || tx_ready;
		// only forwarded words wait on the fifo controller; the rest never stall
		bus_done = wpend_r && (!fwd || slot_free);
		word_take = dp_wr && bus_done;
		load_slot = fwd && slot_free;
		buf_done = word_take && (((st_r == ST_CMDB) && (twords_r == 10'h000))
			|| (in_data && (wcnt_inc == twords_r)));
		clr_hit = wpend_r && bus_done && (addr_r == OFS_INTCLR);
	end

	////////////////////////////////////////////////////////////////////////////////
	// next values
	always_comb begin
		hreadyout_nxt = hreadyout_r;
		wpend_nxt = wpend_r;
		rpend_nxt = rpend_r;
		addr_nxt = addr_r;
		hrdata_nxt = hrdata_r;
		st_nxt = st_r;
		wcnt_nxt = wcnt_r;
		ioc_nxt = ioc_r;
		align_nxt = align_r;
		skip_nxt = skip_r;
		flane_nxt = flane_r;
		elane_nxt = elane_r;
		dwords_nxt = dwords_r;
		twords_nxt = twords_r;
		padcnt_nxt = padcnt_r;
		en_nxt = en_r;
		sts_set = 2'h0;
		tx_valid_nxt = tx_valid_r;
		tx_data_nxt = tx_data_r;
		tx_ben_nxt = tx_ben_r;
		tx_last_nxt = tx_last_r;

		// every transfer gets at least one wait state so the data phase is registered
		if (addr_take) begin
			hreadyout_nxt = 1'b0;
			wpend_nxt = hwrite;
			rpend_nxt = !hwrite;
			addr_nxt = haddr[7:0];
		end else if (bus_done || rpend_r) begin
			hreadyout_nxt = 1'b1;
			wpend_nxt = 1'b0;
			rpend_nxt = 1'b0;
		end

		if (rpend_r) begin
			case (addr_r)
				OFS_STATUS: hrdata_nxt = {26'h000_0000, st_r, 2'h0, sts_r};
				OFS_INTEN: hrdata_nxt = {30'h0000_0000, en_r};
				OFS_CMDINFO: hrdata_nxt = {ioc_r, 5'h00, align_r, 3'h0, skip_r, flane_r, 6'h00, dwords_r};
				OFS_PADCNT: hrdata_nxt = {16'h0000, padcnt_r};
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end

		if (wpend_r && bus_done && (addr_r == OFS_INTEN)) begin
			en_nxt = hwdata[1:0];
		end

		// command words arrive before data in a fixed order
		if (word_take) begin
			case (st_r)
				ST_CMDA: begin
					ioc_nxt = dec_ioc;
					align_nxt = hwdata[ALIGN_HI:ALIGN_LO];
					skip_nxt = dec_skip;
					flane_nxt = dec_flane;
					elane_nxt = dec_elane;
					dwords_nxt = dec_dwords;
					twords_nxt = dec_twords;
					sts_set[STS_ERROR] = dec_bad;
					st_nxt = ST_CMDB;
				end
				ST_CMDB: begin
					wcnt_nxt = 10'h000;
					if (twords_r == 10'h000) begin
						st_nxt = ST_CMDA;
					end else if (dwords_r == 10'h000) begin
						st_nxt = ST_PAD;
					end else begin
						st_nxt = ST_DATA;
					end
				end
				ST_DATA, ST_PAD: begin
					wcnt_nxt = wcnt_inc;
					if (st_r == ST_PAD) begin
						padcnt_nxt = padcnt_r + 16'h0001;
					end
					if (wcnt_inc == twords_r) begin
						st_nxt = ST_CMDA;
					end else if (wcnt_inc >= dwords_r) begin
						st_nxt = ST_PAD;
					end else begin
						st_nxt = ST_DATA;
					end
				end
				default: st_nxt = ST_CMDA;
			endcase
		end

		sts_set[STS_LOADED] = buf_done && ioc_r;

		// set beats a clear arriving in the same cycle
		sts_nxt = sts_r;
		if (clr_hit) begin
			sts_nxt = sts_r & ~hwdata[1:0];
		end
		sts_nxt = sts_nxt | sts_set;

		irq_nxt = |(sts_r & en_r);

		if (load_slot) begin
			tx_valid_nxt = 1'b1;
			tx_data_nxt = hwdata;
			tx_ben_nxt = cur_ben;
			tx_last_nxt = (wcnt_r == dwords_r - 10'h001);
		end else if (tx_ready) begin
			tx_valid_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_r <= 1'b1;
			wpend_r <= 1'b0;
			rpend_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			st_r <= ST_CMDA;
			wcnt_r <= 10'h000;
			ioc_r <= 1'b0;
			align_r <= ALIGN_4;
			skip_r <= 3'h0;
			flane_r <= 2'h0;
			elane_r <= 2'h0;
			dwords_r <= 10'h000;
			twords_r <= 10'h000;
			padcnt_r <= 16'h0000;
			sts_r <= STS_RESET;
			en_r <= EN_RESET;
			irq_r <= 1'b0;
			tx_valid_r <= 1'b0;
			tx_data_r <= 32'h0000_0000;
			tx_ben_r <= 4'h0;
			tx_last_r <= 1'b0;
		end else begin
			hreadyout_r <= hreadyout_nxt;
			wpend_r <= wpend_nxt;
			rpend_r <= rpend_nxt;
			addr_r <= addr_nxt;
			hrdata_r <= hrdata_nxt;
			st_r <= st_nxt;
			wcnt_r <= wcnt_nxt;
			ioc_r <= ioc_nxt;
			align_r <= align_nxt;
			skip_r <= skip_nxt;
			flane_r <= flane_nxt;
			elane_r <= elane_nxt;
			dwords_r <= dwords_nxt;
			twords_r <= twords_nxt;
			padcnt_r <= padcnt_nxt;
			sts_r <= sts_nxt;
			en_r <= en_nxt;
			irq_r <= irq_nxt;
			tx_valid_r <= tx_valid_nxt;
			tx_data_r <= tx_data_nxt;
			tx_ben_r <= tx_ben_nxt;
			tx_last_r <= tx_last_nxt;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign tx_valid = tx_valid_r;
	assign tx_data = tx_data_r;
	assign tx_ben = tx_ben_r;
	assign tx_last = tx_last_r;
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_stall;
		tx_valid_r && !tx_ready;
	endsequence

	sequence s_cmda_rsv;
		word_take && (st_r == ST_CMDA) && (hwdata[ALIGN_HI:ALIGN_LO] == ALIGN_RSV);
	endsequence

	loaded_set_a: assert property (buf_done && ioc_r |=> sts_r[STS_LOADED])
		else $error("loaded flag not set after buffer end");

	no_loaded_a: assert property (!sts_r[STS_LOADED] && !(buf_done && ioc_r) |=> !sts_r[STS_LOADED])
		else $error("loaded flag set without cause");

	irq_route_a: assert property (##1 irq_r == $past(|(sts_r & en_r)))
		else $error("interrupt does not follow enabled status");

	align_err_a: assert property (s_cmda_rsv |=> sts_r[STS_ERROR])
		else $error("reserved alignment did not flag error");

	end_align_a: assert property (buf_done && in_data && (align_r == ALIGN_32) |-> wcnt_inc[2:0] == 3'h0)
		else $error("buffer end not on 32 byte boundary");

	pad_drop_a: assert property (load_slot |-> (st_r == ST_DATA) && (wcnt_r < dwords_r))
		else $error("padding word forwarded");

	skip_words_a: assert property (dp_wr && in_data && (wcnt_r < {7'h00, skip_r}) |=> !$rose(tx_valid_r))
		else $error("skipped word forwarded");

	first_lane_a: assert property (load_slot && (wcnt_r == {7'h00, skip_r}) |=> tx_ben_r[0] == (flane_r == 2'h0))
		else $error("first lane mask wrong");

	last_word_a: assert property (load_slot && (wcnt_r == dwords_r - 10'h001) |=> tx_last_r)
		else $error("last data word not marked");

	stall_hold_a: assert property (s_stall |=> tx_valid_r && $stable(tx_data_r) && $stable(tx_ben_r))
		else $error("stream word changed while stalled");

	cmd_order_a: assert property (word_take && (st_r == ST_CMDA) |=> st_r == ST_CMDB)
		else $error("second command word not expected next");

endmodule

//--- dv/tcwa_sink.sv
`timescale 1ns/10ps
module tcwa_sink (
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset
	input wire logic slow, // stall most cycles
	input wire logic tx_valid, // word offered
	output logic tx_ready // word taken
);
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	// slow mode takes one cycle in eight so the bus write has to wait
	always_comb begin
		cnt_nxt = cnt_r + 3'h1;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	assign tx_ready = !slow || cnt_r == 3'h0;
endmodule

//--- dv/tb_tx_command_word_a_decoder.sv
`timescale 1ns/10ps
module tb_tx_command_word_a_decoder;
	import tcwa_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_valid, tx_ready, tx_last, irq, rd_ph, slow;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] tx_ben;
	logic [31:0] haddr, hwdata, hrdata, tx_data, seed;
	logic [31:0] tbl [8];
	logic [31:0] rq [$];
	logic [36:0] sq [$];
	int error_cnt, tests_run, pc;

	tcwa_tx_cmd_a dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_ben(tx_ben), .tx_last(tx_last), .irq(irq));
	tcwa_sink sink (.hclk(hclk), .hresetn(hresetn), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chkw(input logic [36:0] g, input logic [36:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		$display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// single transfer; read expectation is judged by the watcher below
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= HTRANS_IDLE;
		hwdata <= d;
		rd_ph <= !w;
		if (!w) rq.push_back(e);
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd_ph <= 1'b0;
		// slave never signals an error response
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic run_buf(input logic [31:0] c);
		int o, e, dw, tot, i;
		logic [3:0] b;
		logic [1:0] en;
		logic [31:0] d;
		o = c[20:16];
		e = o + c[10:0];
		dw = (e + 3) / 4;
		tot = (c[25:24] == ALIGN_16) ? (dw + 3) / 4 * 4 : (c[25:24] == ALIGN_32) ? (dw + 7) / 8 * 8 : dw;
		d = rnd();
		en = d[1:0];
		bus(1'b1, OFS_INTEN, {30'h0, en}, 32'h0);
		bus(1'b0, OFS_INTEN, 32'h0, {30'h0, en});
		bus(1'b1, OFS_TXDATA, c, 32'h0);
		bus(1'b1, OFS_TXDATA, rnd(), 32'h0);
		for (i = 0; i < tot; i++) begin
			d = rnd();
			b = 4'hf;
			if (i == o / 4) b = b & 4'(4'hf << (o % 4));
			if (i == dw - 1 && e % 4 != 0) b = b & 4'(4'hf >> (4 - e % 4));
			if (i >= o / 4 && i < dw && b != 4'h0) sq.push_back({i == dw - 1, b, d});
			bus(1'b1, OFS_TXDATA, d, 32'h0);
		end
		pc += tot - dw;
		bus(1'b0, OFS_CMDINFO, 32'h0, {c[31], 5'h0, c[25:24], 3'h0, c[20:16], 6'h0, 10'(dw)});
		bus(1'b0, OFS_STATUS, 32'h0, {30'h0, c[25:24] == ALIGN_RSV, c[31]});
		chk({31'h0, irq}, {31'h0, |({c[25:24] == ALIGN_RSV, c[31]} & en)});
		bus(1'b1, OFS_INTCLR, 32'h0000_0003, 32'h0);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (rd_ph && hreadyout) chk(hrdata, rq.pop_front());
		if (tx_valid && tx_ready) chkw({tx_last, tx_ben, tx_data}, sq.pop_front());
	end

	// longest run is a few thousand cycles, so this only trips on a hang
	initial begin
		repeat (60000) @(posedge hclk);
		error_cnt++;
		finish_test();
	end

	initial begin
		int k;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = HTRANS_IDLE;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rd_ph = 1'b0;
		slow = 1'b0;
		seed = 32'h0000_6067;
		error_cnt = 0;
		tests_run = 0;
		pc = 0;
		tbl = '{32'h8000_0005, 32'h0100_0007, 32'h8215_0021, 32'h0300_0003,
			32'h7cff_0010, 32'h8200_0040, 32'h811e_0001, 32'h0002_0004};
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, OFS_STATUS, 32'h0, {30'h0, STS_RESET});
		bus(1'b0, OFS_INTEN, 32'h0, {30'h0, EN_RESET});
		bus(1'b0, OFS_PADCNT, 32'h0, 32'h0);
		bus(1'b1, 8'h40, 32'hffff_ffff, 32'h0);
		bus(1'b0, 8'h40, 32'h0, 32'h0);
		bus(1'b0, OFS_INTCLR, 32'h0, 32'h0);
		for (k = 0; k < 8; k++) begin
			slow <= k[0];
			run_buf(tbl[k]);
		end
		for (k = 0; k < 4; k++) begin
			slow <= k[1];
			run_buf((rnd() & 32'h831f_00ff) | 32'h0000_0001);
		end
		bus(1'b0, OFS_PADCNT, 32'h0, {16'h0, 16'(pc)});
		repeat (20) @(posedge hclk);
		chk(32'(sq.size()), 32'h0);
		finish_test();
	end
endmodule
